//--- pkg/homing_consts.vh
/* Constants for the home switch homing sequencer: register offsets,
   reset values, interrupt bit positions, method range and AXI response codes. Definitions only. */
`ifndef HOMING_CONSTS_VH
`define HOMING_CONSTS_VH
// Register byte offsets
`define REG_CTRL 6'h00
`define REG_METHOD 6'h04
`define REG_FAST 6'h08
`define REG_SLOW 6'h0c
`define REG_OFFSET 6'h10
`define REG_STATUS 6'h14
`define REG_POS 6'h18
`define REG_IRQ_STAT 6'h1c
`define REG_IRQ_MASK 6'h20
// Reset values
`define METHOD_RST 8'h00
`define FAST_RST 16'h0064
`define SLOW_RST 16'h000a
// Interrupt bit positions
`define IRQ_DONE 0
`define IRQ_BADM 1
// Method range handled here
`define METHOD_LO 8'h04
`define METHOD_HI 8'h0e
// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

//--- rtl/home_switch_homing_sequencer.v
/*
  Homing sequencer for home-switch methods 4 to 14 with an AXI4-Lite
  register slave. Assumes one clock MCLK, synchronous RST_N, a position
  count from same-clock logic, and home switch and index from pins.
*/
// Added by the designer: the address map and register access over AXI4-Lite.
// Functional notes
// (RULE1) Methods 4,8: rise forward slows, continue forward
// (RULE2) Methods 5,11: fall forward slows, continue forward
// (RULE3) Methods 6,12: rise reverse slows, continue reverse
// (RULE4) Method 7: fall reverse slows, continue reverse
// (RULE5) Method 9: start forward, rise reverse slows
// (RULE6) Method 10: start forward, fall forward slows
// (RULE7) Method 13: start reverse, rise forward slows
// (RULE8) Method 14: start reverse, fall reverse slows
// (RULE9) After slowing, first index latches home position
// (RULE10) Host selects method, signed -2 to 35
// (RULE11) Fast phase fast speed, slow phase slow
// (RULE12) Ignore new triggers while homing runs
// (RULE13) On completion: done output, position gets offset
// (RULE14) Sample switch at start; synced edges, direction-qualified
// (RULE15) Wrong-direction start reverses at first switch transition
`timescale 1ns/1ps
`include "homing_consts.vh"
module home_switch_homing_sequencer (
  // Clock and reset
  input wire MCLK,
  input wire RST_N,
  // AXI4-Lite write channels
  input wire [5:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  // AXI4-Lite read channels
  input wire [5:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // Sensors
  input wire HOME_SWITCH_INPUT,
  input wire ENC_INDEX,
  input wire [31:0] ENC_POS,
  // Motion command and results
  output reg MOTOR_RUN,
  output reg MOTOR_FWD,
  output reg [15:0] SPEED_CMD,
  output reg HOMING_DONE_OUTPUT,
  output reg [31:0] HOME_POS,
  output reg [31:0] ABSOLUTE_POSITION_VALUE,
  output wire IRQ
);
  // States
  localparam ST_IDLE = 2'h0;
  localparam ST_FAST = 2'h1;
  localparam ST_SLOW = 2'h2;

  reg [1:0] state; // Sequencer state
  reg [7:0] homing_method_select; // Signed method code
  reg [15:0] homing_fast_speed; // rpm
  reg [15:0] homing_slow_speed; // rpm
  reg [31:0] home_offset_distance; // Loaded into position at done
  reg [1:0] irq_stat; // Sticky events
  reg [1:0] irq_mask; // Enables onto IRQ
  reg homed; // Position tracks encoder once homed

  // Synchronisers: first stage read only by second
  reg sw_s1, sw_s2, sw_d;
  reg ix_s1, ix_s2, ix_d;
  always @(posedge MCLK) begin
    if (!RST_N) begin
      sw_s1 <= 1'b0;
      sw_s2 <= 1'b0;
      sw_d <= 1'b0;
      ix_s1 <= 1'b0;
      ix_s2 <= 1'b0;
      ix_d <= 1'b0;
    end else begin
      sw_s1 <= HOME_SWITCH_INPUT;
      sw_s2 <= sw_s1;
      sw_d <= sw_s2;
      ix_s1 <= ENC_INDEX;
      ix_s2 <= ix_s1;
      ix_d <= ix_s2;
    end
  end
  wire sw_rise = sw_s2 & ~sw_d; // Inactive to active
  wire sw_fall = ~sw_s2 & sw_d; // Active to inactive
  wire ix_rise = ix_s2 & ~ix_d;

  // Method table: fixed start, start dir when switch inactive,
  // qualifying edge direction, edge is a rise
  reg m_ok, m_fixed, m_dir, m_edir, m_rise;
  always @* begin
    m_ok = 1'b1;
    m_fixed = 1'b0;
    m_dir = 1'b1;
    m_edir = 1'b1;
    m_rise = 1'b1;
    case (homing_method_select)
      8'h04, 8'h08: begin // see RULE1
        m_dir = 1'b1;
        m_edir = 1'b1;
        m_rise = 1'b1;
      end
      8'h05, 8'h0b: begin // see RULE2
        m_dir = 1'b0;
        m_edir = 1'b1;
        m_rise = 1'b0;
      end
      8'h06, 8'h0c: begin // see RULE3
        m_dir = 1'b0;
        m_edir = 1'b0;
        m_rise = 1'b1;
      end
      8'h07: begin // see RULE4
        m_dir = 1'b1;
        m_edir = 1'b0;
        m_rise = 1'b0;
      end
      8'h09: begin // see RULE5
        m_fixed = 1'b1;
        m_dir = 1'b1;
        m_edir = 1'b0;
        m_rise = 1'b1;
      end
      8'h0a: begin // see RULE6
        m_fixed = 1'b1;
        m_dir = 1'b1;
        m_edir = 1'b1;
        m_rise = 1'b0;
      end
      8'h0d: begin // see RULE7
        m_fixed = 1'b1;
        m_dir = 1'b0;
        m_edir = 1'b1;
        m_rise = 1'b1;
      end
      8'h0e: begin // see RULE8
        m_fixed = 1'b1;
        m_dir = 1'b0;
        m_edir = 1'b0;
        m_rise = 1'b0;
      end
      default: begin // Other codes are outside this block
        m_ok = 1'b0;
      end
    endcase
  end

  // AXI write path: address and data may arrive in either order
  reg aw_held, w_held;
  reg [5:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  assign S_AXI_AWREADY = ~aw_held & ~S_AXI_BVALID;
  assign S_AXI_WREADY = ~w_held & ~S_AXI_BVALID;
  wire do_wr = aw_held & w_held & ~S_AXI_BVALID;
  wire [5:0] wa = {aw_addr[5:2], 2'b00}; // Word-aligned byte offset, low bits ignored
  wire wr_ok = (wa <= `REG_IRQ_MASK) && (wa != `REG_STATUS) && (wa != `REG_POS);
  wire start_wr = do_wr & (wa == `REG_CTRL) & w_strb[0] & w_data[0];
  always @(posedge MCLK) begin
    if (!RST_N) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 6'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID & S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID & S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (do_wr) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Configuration registers; method is loaded by the host only
  always @(posedge MCLK) begin
    if (!RST_N) begin
      homing_method_select <= `METHOD_RST;
      homing_fast_speed <= `FAST_RST;
      homing_slow_speed <= `SLOW_RST;
      home_offset_distance <= 32'h0000_0000;
      irq_mask <= 2'b00;
    end else if (do_wr) begin
      if (wa == `REG_METHOD && w_strb[0])
        homing_method_select <= w_data[7:0]; // see RULE10
      if (wa == `REG_FAST && w_strb[0])
        homing_fast_speed[7:0] <= w_data[7:0];
      if (wa == `REG_FAST && w_strb[1])
        homing_fast_speed[15:8] <= w_data[15:8];
      if (wa == `REG_SLOW && w_strb[0])
        homing_slow_speed[7:0] <= w_data[7:0];
      if (wa == `REG_SLOW && w_strb[1])
        homing_slow_speed[15:8] <= w_data[15:8];
      if (wa == `REG_OFFSET)
        home_offset_distance <= w_data;
      if (wa == `REG_IRQ_MASK && w_strb[0])
        irq_mask <= w_data[1:0];
    end
  end

  // Sequencer
  wire start_ok = start_wr & (state == ST_IDLE) & m_ok; // see RULE12
  wire start_bad = start_wr & (state == ST_IDLE) & ~m_ok;
  wire edge_hit = (MOTOR_FWD == m_edir) & (m_rise ? sw_rise : sw_fall); // see RULE14
  wire any_edge = sw_rise | sw_fall;
  wire done_now = (state == ST_SLOW) & ix_rise;
  always @(posedge MCLK) begin
    if (!RST_N) begin
      state <= ST_IDLE;
      MOTOR_RUN <= 1'b0;
      MOTOR_FWD <= 1'b1;
      SPEED_CMD <= 16'h0000;
      HOMING_DONE_OUTPUT <= 1'b0;
      HOME_POS <= 32'h0000_0000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_ok) begin
            state <= ST_FAST;
            MOTOR_RUN <= 1'b1;
            // Switch level taken once, here only; see RULE14
            MOTOR_FWD <= m_fixed ? m_dir : (m_dir ^ sw_s2);
            SPEED_CMD <= homing_fast_speed; // see RULE11
            HOMING_DONE_OUTPUT <= 1'b0;
          end
        end
        ST_FAST: begin
          if (edge_hit) begin
            state <= ST_SLOW;
            SPEED_CMD <= homing_slow_speed; // see RULE11
          end else if ((MOTOR_FWD != m_edir) && any_edge) begin
            MOTOR_FWD <= ~MOTOR_FWD; // see RULE15
          end
        end
        ST_SLOW: begin
          // Direction held; first index is home; see RULE9
          if (ix_rise) begin
            state <= ST_IDLE;
            MOTOR_RUN <= 1'b0;
            SPEED_CMD <= 16'h0000;
            HOME_POS <= ENC_POS;
            HOMING_DONE_OUTPUT <= 1'b1; // see RULE13
          end
        end
        default: begin
          state <= ST_IDLE;
          MOTOR_RUN <= 1'b0;
        end
      endcase
    end
  end

  // Absolute position: equals offset at home, then follows the encoder
  always @(posedge MCLK) begin
    if (!RST_N) begin
      homed <= 1'b0;
      ABSOLUTE_POSITION_VALUE <= 32'h0000_0000;
    end else if (done_now) begin
      homed <= 1'b1;
      ABSOLUTE_POSITION_VALUE <= home_offset_distance; // see RULE13
    end else if (homed) begin
      ABSOLUTE_POSITION_VALUE <= ENC_POS - HOME_POS + home_offset_distance;
    end
  end

  // Sticky events; a set in the clearing cycle wins
  wire [1:0] ev = {start_bad, done_now};
  wire [1:0] clr = (do_wr && wa == `REG_IRQ_STAT && w_strb[0]) ? w_data[1:0] : 2'b00;
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_irq
      always @(posedge MCLK) begin
        if (!RST_N)
          irq_stat[i] <= 1'b0;
        else
          irq_stat[i] <= ev[i] | (irq_stat[i] & ~clr[i]);
      end
    end
  endgenerate
  assign IRQ = |(irq_stat & irq_mask);

  // AXI read path: answer one cycle after the address is taken
  assign S_AXI_ARREADY = ~S_AXI_RVALID;
  wire [5:0] ra = {S_AXI_ARADDR[5:2], 2'b00};
  reg [31:0] rd;
  reg rd_ok;
  always @* begin
    rd = 32'h0000_0000;
    rd_ok = 1'b1;
    case (ra)
      `REG_CTRL: rd = 32'h0000_0000;
      `REG_METHOD: rd = {{24{homing_method_select[7]}}, homing_method_select};
      `REG_FAST: rd = {16'h0000, homing_fast_speed};
      `REG_SLOW: rd = {16'h0000, homing_slow_speed};
      `REG_OFFSET: rd = home_offset_distance;
      `REG_STATUS: rd = {26'h0, homed, HOMING_DONE_OUTPUT, MOTOR_FWD, MOTOR_RUN, state};
      `REG_POS: rd = ABSOLUTE_POSITION_VALUE;
      `REG_IRQ_STAT: rd = {30'h0, irq_stat};
      `REG_IRQ_MASK: rd = {30'h0, irq_mask};
      default: rd_ok = 1'b0;
    endcase
  end
  always @(posedge MCLK) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `RESP_OKAY;
    end else if (S_AXI_ARVALID & S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd;
      S_AXI_RRESP <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end
endmodule // home_switch_homing_sequencer

//--- verif/axis_model.sv
/* Axis model: circular travel, home switch window, index marks.
   Assumes motor commands on the same clock as the sequencer. */
`timescale 1ns/1ps
module axis_model (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Motion command and parking
  input wire run,
  input wire fwd,
  input wire load,
  input wire [7:0] load_pos,
  // Sensor outputs
  output wire sw,
  output wire idx,
  output wire [31:0] enc_pos
);
  reg [7:0] pos; // Wraps, so every edge is reachable both ways
  // One count per cycle while running
  always @(posedge clk) begin
    if (!rst_n || load) begin
      pos <= rst_n ? load_pos : 8'h14;
    end else if (run) begin
      pos <= fwd ? pos + 8'h01 : pos - 8'h01;
    end
  end
  // Window edges sit well clear of the index marks
  assign sw = (pos >= 8'h5a) && (pos < 8'haa);
  // Four counts wide: longer than the two-stage synchroniser
  assign idx = (pos[5:0] < 6'h04);
  assign enc_pos = {24'h000000, pos};
endmodule // axis_model

//--- verif/homing_chk.sv
/* Checker for the homing sequencer motion outputs and read channel.
   Assumes it is bound to the sequencer top, one clock MCLK. */
`timescale 1ns/1ps
module homing_chk (
  // Clock and reset
  input wire MCLK,
  input wire RST_N,
  // Read channel
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire S_AXI_RVALID,
  // Sensors
  input wire HOME_SWITCH_INPUT,
  input wire ENC_INDEX,
  // Motion
  input wire MOTOR_RUN,
  input wire MOTOR_FWD,
  input wire [15:0] SPEED_CMD,
  input wire HOMING_DONE_OUTPUT
);
  reg sw_last; // Switch level one cycle back
  reg [3:0] sw_age; // Cycles since the switch moved, saturating
  // While running, speed and direction may only change shortly after a switch transition
  always @(posedge MCLK) begin
    if (!RST_N) begin
      sw_last <= 1'b0;
      sw_age <= 4'hf;
    end else begin
      sw_last <= HOME_SWITCH_INPUT;
      if (HOME_SWITCH_INPUT != sw_last) begin
        sw_age <= 4'h0;
      end else if (sw_age != 4'hf) begin
        sw_age <= sw_age + 4'h1;
      end
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // Two running cycles in a row
  sequence s_moving;
    MOTOR_RUN ##1 MOTOR_RUN;
  endsequence
  // Completion seen at this edge
  sequence s_done;
    $rose(HOMING_DONE_OUTPUT);
  endsequence
  a_start_clears: assert property ($rose(MOTOR_RUN) |-> !HOMING_DONE_OUTPUT)
    else $error("done high at start");
  a_done_stops: assert property (s_done |-> !MOTOR_RUN && SPEED_CMD == 16'h0000)
    else $error("motion at completion");
  a_done_index: assert property (s_done |-> $past(ENC_INDEX, 3))
    else $error("completion without index");
  a_slow_dir: assert property (s_moving ##0 $changed(SPEED_CMD) |-> $stable(MOTOR_FWD))
    else $error("direction changed on slowdown");
  a_slow_cause: assert property (s_moving ##0 $changed(SPEED_CMD) |-> sw_age < 4'h8)
    else $error("slowdown without switch edge");
  a_flip_cause: assert property (s_moving ##0 $changed(MOTOR_FWD)
    |-> sw_age < 4'h8 && $stable(SPEED_CMD))
    else $error("reversal without switch edge");
  a_run_speed: assert property (!MOTOR_RUN |-> SPEED_CMD == 16'h0000)
    else $error("speed command without motion");
  a_rd_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read not answered");
endmodule // homing_chk

//--- verif/tb_top.sv
/* Testbench: bus tasks, axis model and a sweep of methods.
   Assumes the sequencer and the axis model are compiled first. */
`timescale 1ns/1ps
module tb_top;
  reg mclk = 1'b0; // System clock
  reg rst_n = 1'b0; // Synchronous reset
  reg [5:0] awaddr = 6'h00, araddr = 6'h00;
  reg [31:0] wdata = 32'h0, rd_val;
  reg awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  reg load = 1'b0; // Parks the axis between runs
  reg [7:0] lpos = 8'h14;
  reg [1:0] rd_resp, wr_resp;
  wire awready, wready, bvalid, arready, rvalid, sw, idx, run, fwd, done, irq;
  wire [1:0] bresp, rresp;
  wire [15:0] speed;
  wire [31:0] rdata, enc_pos, home_pos, abs_pos;
  integer n_errors = 0, samples_checked = 0, cycles = 0, i;
  always #12.5 mclk = ~mclk;
  home_switch_homing_sequencer dut (.MCLK(mclk), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .HOME_SWITCH_INPUT(sw), .ENC_INDEX(idx), .ENC_POS(enc_pos),
    .MOTOR_RUN(run), .MOTOR_FWD(fwd), .SPEED_CMD(speed), .HOMING_DONE_OUTPUT(done),
    .HOME_POS(home_pos), .ABSOLUTE_POSITION_VALUE(abs_pos), .IRQ(irq));
  axis_model axis (.clk(mclk), .rst_n(rst_n), .run(run), .fwd(fwd), .load(load),
    .load_pos(lpos), .sw(sw), .idx(idx), .enc_pos(enc_pos));
  // Cut a hang short
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors = n_errors + 1;
      results;
    end
  end
  task results;
    begin
      if (n_errors == 0 && samples_checked > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Write: both channels offered together, each released when taken
  task wr(input [5:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      fork
        begin do @(posedge mclk); while (!awready); awv <= 1'b0; end
        begin do @(posedge mclk); while (!wready); wv <= 1'b0; end
      join
      do @(posedge mclk); while (!bvalid);
      wr_resp = bresp;
      bready <= 1'b0;
    end
  endtask
  task rd(input [5:0] a);
    begin
      @(posedge mclk);
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      do @(posedge mclk); while (!arready);
      arv <= 1'b0;
      do @(posedge mclk); while (!rvalid);
      rd_val = rdata;
      rd_resp = rresp;
      rready <= 1'b0;
    end
  endtask
  // Start direction and qualifying direction, forward = 1
  function [1:0] exp_dir(input [7:0] m, input s);
    case (m)
      8'h04, 8'h08: exp_dir = {~s, 1'b1};
      8'h05, 8'h0b: exp_dir = {s, 1'b1};
      8'h06, 8'h0c: exp_dir = {s, 1'b0};
      8'h07: exp_dir = {~s, 1'b0};
      8'h09: exp_dir = 2'b10;
      8'h0a: exp_dir = 2'b11;
      8'h0d: exp_dir = 2'b01;
      default: exp_dir = 2'b00;
    endcase
  endfunction
  task t_regs;
    begin
      rd(6'h08);
      chk(rd_val, 32'h00000064);
      rd(6'h0c);
      chk(rd_val, 32'h0000000a);
      wr(6'h04, 32'h000000fe);
      chk(wr_resp, 2'b00);
      rd(6'h04);
      chk(rd_val, 32'hfffffffe);
      wr(6'h14, 32'h00000001);
      chk(wr_resp, 2'b10);
      rd(6'h24);
      chk(rd_resp, 2'b10);
    end
  endtask
  // Unhandled method: event only, no motion
  task t_bad;
    begin
      wr(6'h20, 32'h00000003);
      wr(6'h04, 32'h00000003);
      wr(6'h00, 32'h00000001);
      chk({run, irq}, 2'b01);
      wr(6'h1c, 32'h00000002);
      chk(irq, 1'b0);
    end
  endtask
  task t_method(input [7:0] m, input s);
    reg [1:0] e;
    begin
      e = exp_dir(m, s);
      @(posedge mclk);
      lpos <= s ? 8'h8c : 8'h14;
      load <= 1'b1;
      @(posedge mclk);
      load <= 1'b0;
      repeat (4) @(posedge mclk);
      wr(6'h04, {24'h000000, m});
      wr(6'h00, 32'h00000001);
      chk({run, fwd, speed}, {1'b1, e[1], 16'h0064});
      while (speed !== 16'h000a) @(posedge mclk);
      chk(fwd, e[0]);
      wr(6'h00, 32'h00000001);
      chk({run, fwd, speed}, {1'b1, e[0], 16'h000a});
      while (done !== 1'b1) @(posedge mclk);
      chk({irq, abs_pos[31:8]}, 25'h1123400);
      chk({home_pos[31:8], home_pos[5:2]}, 28'h0000000);
      rd(6'h14);
      chk(rd_val, {26'h0, 2'b11, e[0], 3'b000});
      wr(6'h1c, 32'h00000001);
      chk(irq, 1'b0);
    end
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_regs;
    wr(6'h10, 32'h12340000);
    t_bad;
    for (i = 4; i <= 14; i = i + 1) begin
      t_method(i[7:0], 1'b0);
      t_method(i[7:0], 1'b1);
    end
    results;
  end
endmodule // tb_top
bind home_switch_homing_sequencer homing_chk u_chk (.MCLK, .RST_N, .S_AXI_ARVALID,
  .S_AXI_ARREADY, .S_AXI_RVALID, .HOME_SWITCH_INPUT, .ENC_INDEX, .MOTOR_RUN,
  .MOTOR_FWD, .SPEED_CMD, .HOMING_DONE_OUTPUT);
